// ===== rtl/res_params.svh
// Constants for the rail enable sequencer
`ifndef RES_PARAMS_SVH
`define RES_PARAMS_SVH
`define RES_OFF_SRC_CFG 8'h08
`define RES_OFF_EDGE_DLY 8'h09
`define RES_OFF_PEER_MASK 8'h0A
`define RES_BIT_STEP 5
`define RES_SEL_HI 4
`define RES_SEL_LO 2
`define RES_BIT_SHARED_MASK 1
`define RES_BIT_SWB_MASK 0
`define RES_OFF_DLY_HI 5
`define RES_OFF_DLY_LO 3
`define RES_ON_DLY_HI 2
`define RES_ON_DLY_LO 0
`define RES_SRC_CFG_RESET 8'hC0
`define RES_EDGE_DLY_RESET 8'h00
`define RES_PEER_MASK_RESET 8'h00
`define RES_SEL_ALWAYS_ON 3'h7
`define RES_CLK_KHZ 50000
`define RES_MS_2 2
`define RES_MS_4 4
`define RES_MS_8 8
`define RES_MS_16 16
`define RES_MS_24 24
`define RES_MS_32 32
`define RES_MS_64 64
`define RES_CYC(ms) (32'((ms) * `RES_CLK_KHZ))
`endif

// ===== rtl/res_pkg.sv
// Types for the rail enable sequencer
`default_nettype none
package res_pkg;
  typedef enum logic [2:0] {
    RES_SRC_FIRST, RES_SRC_SECOND, RES_SRC_FIFTH, RES_SRC_FOURTH,
    RES_SRC_THIRD, RES_SRC_THIRD_FOURTH, RES_SRC_SIXTH, RES_SRC_ALWAYS
  } res_src_t;
  typedef enum logic {RES_STEP_10MV, RES_STEP_25MV} res_step_t;
endpackage
`default_nettype wire

// ===== rtl/res_edge_delay.sv
// Edge delay filter: follows an input after a separate rise or fall delay
`timescale 1ns/1ps
`default_nettype none
`include "res_params.svh"
module res_edge_delay (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic level_in,
  input wire logic [2:0] rise_code,
  input wire logic [2:0] fall_code,
  output logic level_out
);
  logic [31:0] cnt_q;
  logic [31:0] target;
  logic [2:0] code;
  logic out_q;

  assign code = level_in ? rise_code : fall_code;

  // Code 110 is 32 ms and 011 is 8 ms on both edges
  always_comb begin
    unique case (code) // [R8] [R11]
      3'h0: target = 32'h0;
      3'h1: target = `RES_CYC(`RES_MS_2);
      3'h2: target = `RES_CYC(`RES_MS_4);
      3'h3: target = `RES_CYC(`RES_MS_8);
      3'h4: target = `RES_CYC(`RES_MS_16);
      3'h5: target = `RES_CYC(`RES_MS_24);
      3'h6: target = `RES_CYC(`RES_MS_32);
      3'h7: target = `RES_CYC(`RES_MS_64);
    endcase
  end

  // Counter restarts whenever the input returns to the output level
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 32'h0;
    end else if (level_in == out_q) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_q <= 1'b0;
    end else if (level_in != out_q && cnt_q + 32'h1 >= target) begin
      out_q <= level_in; // [R6] [R7]
    end
  end

  assign level_out = out_q;

  a_zero_delay_follow: assert property (@(posedge mclk) disable iff (!resetn)
    (level_in != out_q && code == 3'h0) |=> (out_q == $past(level_in))) // [R8]
    else $error("zero delay edge not followed in one cycle");
endmodule // res_edge_delay
`default_nettype wire

// ===== rtl/res_rail_enable.sv
// Rail enable sequencer: source select, edge delays and peer power-good gating
// Behaviour
// [R1] Three-bit selector picks control input first, second, fifth, fourth, third, third&fourth, sixth.
// [R2] Selector 111 feeds constant one, no pin needed.
// [R3] Mask bit 0 requires that peer power-good; 1 drops it.
// [R4] Source register bit 1 masks shared rail good, bit 0 switch B one good.
// [R5] Peer mask register bits map regulator3, regulator2, switch A1, rails 6..3, rail one.
// [R6] Bits 5:3 select delay from enable falling edge to rail disable.
// [R7] Bits 2:0 select delay from enable rising edge to rail enable.
// [R8] Delay codes: 0, 2, 4, 8, 16, 24, 32, 64 ms, tolerance ten percent.
// [R9] Bit 5 sets voltage increment: 0 is 10 mV, 1 is 25 mV.
// [R10] Host should change the increment bit only through the offline configuration flow.
// [R11] Code 110 is 32 ms; code 011 is 8 ms on both edges.
// [R12] Rail enabled when delayed source high and all unmasked peer goods true.
`timescale 1ns/1ps
`default_nettype none
`include "res_params.svh"
module res_rail_enable (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [5:0] control_input,
  input wire logic shared_switch_regulator_rail_good,
  input wire logic load_switch_b_one_good,
  input wire logic linear_regulator_three_good,
  input wire logic linear_regulator_two_good,
  input wire logic load_switch_a_one_good,
  input wire logic converter_rail_six_good,
  input wire logic converter_rail_five_good,
  input wire logic converter_rail_four_good,
  input wire logic controller_rail_three_good,
  input wire logic controller_rail_one_good,
  input wire logic otp_load,
  input wire logic [7:0] otp_src_cfg,
  input wire logic [7:0] otp_edge_dly,
  input wire logic [7:0] otp_peer_mask,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_addr_err,
  output logic rail_one_voltage_increment,
  output logic rail_enable
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] src_cfg_q;
  logic [7:0] edge_dly_q;
  logic [7:0] peer_mask_q;
  logic [7:0] rdata_q;
  logic addr_err_q;

  // OTP image load wins over a host write in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      src_cfg_q <= `RES_SRC_CFG_RESET;
    end else if (otp_load) begin
      src_cfg_q <= otp_src_cfg;
    end else if (reg_wr && reg_addr == `RES_OFF_SRC_CFG) begin
      src_cfg_q <= reg_wdata; // [R10]
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      edge_dly_q <= `RES_EDGE_DLY_RESET;
    end else if (otp_load) begin
      edge_dly_q <= otp_edge_dly;
    end else if (reg_wr && reg_addr == `RES_OFF_EDGE_DLY) begin
      edge_dly_q <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      peer_mask_q <= `RES_PEER_MASK_RESET;
    end else if (otp_load) begin
      peer_mask_q <= otp_peer_mask;
    end else if (reg_wr && reg_addr == `RES_OFF_PEER_MASK) begin
      peer_mask_q <= reg_wdata;
    end
  end

  // Unmapped reads return zero and raise the error flag for that read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
      addr_err_q <= 1'b0;
    end else if (reg_rd || reg_wr) begin
      unique case (reg_addr)
        `RES_OFF_SRC_CFG: begin
          rdata_q <= src_cfg_q;
          addr_err_q <= 1'b0;
        end
        `RES_OFF_EDGE_DLY: begin
          rdata_q <= edge_dly_q;
          addr_err_q <= 1'b0;
        end
        `RES_OFF_PEER_MASK: begin
          rdata_q <= peer_mask_q;
          addr_err_q <= 1'b0;
        end
        default: begin
          rdata_q <= 8'h00;
          addr_err_q <= 1'b1;
        end
      endcase
    end else begin
      addr_err_q <= 1'b0;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_addr_err = addr_err_q;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [15:0] pin_raw;
  logic [15:0] pin_meta_q;
  logic [15:0] pin_sync_q;

  assign pin_raw = {control_input, shared_switch_regulator_rail_good, load_switch_b_one_good,
    linear_regulator_three_good, linear_regulator_two_good, load_switch_a_one_good,
    converter_rail_six_good, converter_rail_five_good, converter_rail_four_good,
    controller_rail_three_good, controller_rail_one_good};

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= 16'h0000;
      pin_sync_q <= 16'h0000;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  logic [5:0] ctl_s;
  logic [7:0] peer_good_s;
  logic [1:0] local_good_s;

  assign ctl_s = pin_sync_q[15:10];
  assign local_good_s = pin_sync_q[9:8]; // [R4]
  assign peer_good_s = pin_sync_q[7:0]; // [R5]

  // ---------------------------------------------------------------
  // Source select
  // ---------------------------------------------------------------
  res_pkg::res_src_t sel;
  logic src_level;

  assign sel = res_pkg::res_src_t'(src_cfg_q[`RES_SEL_HI:`RES_SEL_LO]);

  always_comb begin
    unique case (sel) // [R1]
      res_pkg::RES_SRC_FIRST: src_level = ctl_s[0];
      res_pkg::RES_SRC_SECOND: src_level = ctl_s[1];
      res_pkg::RES_SRC_FIFTH: src_level = ctl_s[4];
      res_pkg::RES_SRC_FOURTH: src_level = ctl_s[3];
      res_pkg::RES_SRC_THIRD: src_level = ctl_s[2];
      res_pkg::RES_SRC_THIRD_FOURTH: src_level = ctl_s[2] & ctl_s[3];
      res_pkg::RES_SRC_SIXTH: src_level = ctl_s[5];
      res_pkg::RES_SRC_ALWAYS: src_level = 1'b1; // [R2]
    endcase
  end

  // ---------------------------------------------------------------
  // Edge delay and peer gating
  // ---------------------------------------------------------------
  logic src_delayed;

  res_edge_delay u_delay (
    .mclk(mclk),
    .resetn(resetn),
    .level_in(src_level),
    .rise_code(edge_dly_q[`RES_ON_DLY_HI:`RES_ON_DLY_LO]), // [R7]
    .fall_code(edge_dly_q[`RES_OFF_DLY_HI:`RES_OFF_DLY_LO]), // [R6]
    .level_out(src_delayed)
  );

  logic [9:0] good_all;
  logic [9:0] mask_all;
  logic [9:0] term_ok;
  logic en_q;

  assign good_all = {peer_good_s, local_good_s};
  assign mask_all = {peer_mask_q, src_cfg_q[`RES_BIT_SHARED_MASK], src_cfg_q[`RES_BIT_SWB_MASK]};

  // A masked good is forced true so it drops out of the AND
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_term
      assign term_ok[gi] = mask_all[gi] | good_all[gi]; // [R3]
    end
  endgenerate

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= src_delayed & (&term_ok); // [R12]
    end
  end

  assign rail_enable = en_q;
  assign rail_one_voltage_increment = src_cfg_q[`RES_BIT_STEP]; // [R9]

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_enable_needs_goods: assert property (@(posedge mclk) disable iff (!resetn)
    en_q |-> ($past(src_delayed) && $past(&term_ok))) // [R12]
    else $error("rail enabled without source or peer good");
  a_masked_peer_ignored: assert property (@(posedge mclk) disable iff (!resetn)
    (src_delayed && (&mask_all)) |=> en_q) // [R3]
    else $error("fully masked rail not enabled");
  a_unmasked_peer_low: assert property (@(posedge mclk) disable iff (!resetn)
    (!mask_all[2] && !good_all[2]) |=> !en_q) // [R5]
    else $error("unmasked peer low but rail enabled");
  a_shared_mask_low: assert property (@(posedge mclk) disable iff (!resetn)
    (!src_cfg_q[`RES_BIT_SHARED_MASK] && !local_good_s[1]) |=> !en_q) // [R4]
    else $error("shared rail good ignored while unmasked");
  a_always_on_source: assert property (@(posedge mclk) disable iff (!resetn)
    (sel == res_pkg::RES_SRC_ALWAYS) |-> src_level) // [R2]
    else $error("constant one source not high");
  a_pair_source: assert property (@(posedge mclk) disable iff (!resetn)
    (sel == res_pkg::RES_SRC_THIRD_FOURTH) |-> (src_level == (ctl_s[2] && ctl_s[3]))) // [R1]
    else $error("third and fourth pair wrong");
  a_fifth_source: assert property (@(posedge mclk) disable iff (!resetn)
    (sel == res_pkg::RES_SRC_FIFTH) |-> (src_level == ctl_s[4])) // [R1]
    else $error("selector 010 not fifth input");
  a_step_follows: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_wr && !otp_load && reg_addr == `RES_OFF_SRC_CFG)
      |=> (rail_one_voltage_increment == $past(reg_wdata[`RES_BIT_STEP]))) // [R9]
    else $error("increment bit not written");
  // Only a rise from a low output starts the rise delay; a cut fall keeps the output high
  a_no_early_rise: assert property (@(posedge mclk) disable iff (!resetn)
    ($rose(src_level) && !src_delayed && edge_dly_q[`RES_ON_DLY_HI:`RES_ON_DLY_LO] == 3'h1)
      |=> !src_delayed [*8]) // [R7]
    else $error("rise delay ended too early");
endmodule // res_rail_enable
`default_nettype wire

// ===== tb/res_ctl_model.sv
// System controller model driving the six control input pins
`timescale 1ns/1ps
`default_nettype none
module res_ctl_model (
  input wire logic mclk,
  output logic [5:0] control_input
);
  initial control_input = 6'h00;
  // Pins move only just after an edge, so the two-flop sync sees clean levels
  task automatic drive(input logic [5:0] v);
    @(posedge mclk);
    control_input <= v;
  endtask
endmodule // res_ctl_model
`default_nettype wire

// ===== tb/rail_enable_sequencer_tb.sv
// Self-checking bench for the rail enable sequencer
`timescale 1ns/1ps
`default_nettype none
module rail_enable_sequencer_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] gd = 10'h3FF;
  logic otp_load = 1'b0;
  logic [7:0] otp_src = 8'h00;
  logic [7:0] otp_dly = 8'h00;
  logic [7:0] otp_msk = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] d;
  logic e;
  wire logic [5:0] ctl;
  wire logic [7:0] reg_rdata;
  wire logic reg_addr_err;
  wire logic incr;
  wire logic rail;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  // Pin pattern that each selector code 000..110 should follow
  localparam logic [5:0] PIN [0:6] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20};

  always #10 mclk = ~mclk;

  res_ctl_model ctl_u (.mclk(mclk), .control_input(ctl));

  res_rail_enable dut_u (
    .mclk(mclk), .resetn(resetn), .control_input(ctl),
    .shared_switch_regulator_rail_good(gd[1]), .load_switch_b_one_good(gd[0]),
    .linear_regulator_three_good(gd[9]), .linear_regulator_two_good(gd[8]),
    .load_switch_a_one_good(gd[7]), .converter_rail_six_good(gd[6]),
    .converter_rail_five_good(gd[5]), .converter_rail_four_good(gd[4]),
    .controller_rail_three_good(gd[3]), .controller_rail_one_good(gd[2]),
    .otp_load(otp_load), .otp_src_cfg(otp_src), .otp_edge_dly(otp_dly), .otp_peer_mask(otp_msk),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_addr_err(reg_addr_err),
    .rail_one_voltage_increment(incr), .rail_enable(rail)
  );

  task automatic tally_and_finish;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs fewer than two thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    e = reg_addr_err;
  endtask

  task automatic t_regs;
    rd(8'h08);
    chk(d, 8'hC0);
    rd(8'h09);
    chk(d, 8'h00);
    chk({7'h00, incr}, 8'h00);
    wr(8'h09, 8'h3F);
    rd(8'h09);
    chk(d, 8'h3F);
    wr(8'h0A, 8'hA5);
    rd(8'h0A);
    chk(d, 8'hA5);
    rd(8'h0B);
    chk({e, d[6:0]}, 8'h80);
    // Step bit set once while the rail is idle, never mid-ramp
    wr(8'h08, 8'h20);
    tick(2);
    chk({7'h00, incr}, 8'h01);
    wr(8'h09, 8'h00);
  endtask

  task automatic t_sel;
    wr(8'h0A, 8'hFF);
    for (int s = 0; s < 7; s++) begin
      wr(8'h08, {3'h0, 3'(s), 2'h3});
      ctl_u.drive(~PIN[s]);
      tick(8);
      chk({7'h00, rail}, 8'h00);
      ctl_u.drive(PIN[s]);
      tick(8);
      chk({7'h00, rail}, 8'h01);
    end
    wr(8'h08, 8'h17);
    ctl_u.drive(6'h04);
    tick(8);
    chk({7'h00, rail}, 8'h00);
    wr(8'h08, 8'h1F);
    ctl_u.drive(6'h00);
    tick(8);
    chk({7'h00, rail}, 8'h01);
  endtask

  task automatic t_mask;
    wr(8'h08, 8'h1C);
    wr(8'h0A, 8'h00);
    for (int i = 0; i < 10; i++) begin
      gd <= ~(10'h001 << i);
      tick(8);
      chk({7'h00, rail}, 8'h00);
      if (i < 2) wr(8'h08, 8'h1C | (8'h01 << i));
      else wr(8'h0A, 8'h01 << (i - 2));
      tick(8);
      chk({7'h00, rail}, 8'h01);
      wr(8'h08, 8'h1C);
      wr(8'h0A, 8'h00);
      gd <= 10'h3FF;
      @(posedge mclk);
    end
  endtask

  // Every nonzero code holds both edges back well beyond twenty cycles
  task automatic t_codes;
    ctl_u.drive(6'h01);
    tick(8);
    chk({7'h00, rail}, 8'h01);
    for (int c = 1; c < 8; c++) begin
      wr(8'h09, {5'h00, 3'(c)});
      ctl_u.drive(6'h00);
      tick(8);
      chk({7'h00, rail}, 8'h00);
      ctl_u.drive(6'h01);
      tick(20);
      chk({7'h00, rail}, 8'h00);
      wr(8'h09, {2'h0, 3'(c), 3'h0});
      tick(8);
      chk({7'h00, rail}, 8'h01);
      ctl_u.drive(6'h00);
      tick(20);
      chk({7'h00, rail}, 8'h01);
      ctl_u.drive(6'h01);
      tick(20);
      chk({7'h00, rail}, 8'h01);
    end
  endtask

  // Loads the three images; a colliding host write to the source register must lose
  task automatic otp_drive(input logic [7:0] s, input logic [7:0] dl, input logic [7:0] m, input logic w);
    @(posedge mclk);
    otp_src <= s;
    otp_dly <= dl;
    otp_msk <= m;
    otp_load <= 1'b1;
    reg_wr <= w;
    reg_addr <= 8'h08;
    reg_wdata <= 8'h00;
    @(posedge mclk);
    otp_load <= 1'b0;
    reg_wr <= 1'b0;
  endtask

  task automatic t_delay;
    wr(8'h08, 8'h03);
    wr(8'h0A, 8'hFF);
    tick(8);
    ctl_u.drive(6'h01);
    tick(3);
    chk({7'h00, rail}, 8'h00);
    tick(1);
    chk({7'h00, rail}, 8'h01);
    ctl_u.drive(6'h00);
    tick(3);
    chk({7'h00, rail}, 8'h01);
    tick(1);
    chk({7'h00, rail}, 8'h00);
    wr(8'h09, 8'h01);
    ctl_u.drive(6'h01);
    tick(300);
    chk({7'h00, rail}, 8'h00);
    ctl_u.drive(6'h00);
    wr(8'h09, 8'h08);
    ctl_u.drive(6'h01);
    tick(8);
    chk({7'h00, rail}, 8'h01);
    ctl_u.drive(6'h00);
    tick(300);
    chk({7'h00, rail}, 8'h01);
  endtask

  task automatic t_otp;
    otp_drive(8'h3E, 8'h2D, 8'h5A, 1'b1);
    rd(8'h08);
    chk(d, 8'h3E);
    rd(8'h09);
    chk(d, 8'h2D);
    rd(8'h0A);
    chk(d, 8'h5A);
    chk({6'h00, incr, rail}, 8'h03);
    @(posedge mclk);
    gd <= 10'h3F7;
    tick(8);
    chk({7'h00, rail}, 8'h01);
    @(posedge mclk);
    gd <= 10'h3FB;
    tick(8);
    chk({7'h00, rail}, 8'h00);
    @(posedge mclk);
    gd <= 10'h3FF;
    tick(8);
    chk({7'h00, rail}, 8'h01);
    @(posedge mclk);
    resetn <= 1'b0;
    tick(2);
    chk({6'h00, incr, rail}, 8'h00);
    @(posedge mclk);
    resetn <= 1'b1;
    rd(8'h08);
    chk(d, 8'hC0);
    rd(8'h0A);
    chk(d, 8'h00);
    otp_drive(8'hC9, 8'h00, 8'hA5, 1'b0);
    rd(8'h08);
    chk(d, 8'hC9);
    tick(8);
    chk({6'h00, incr, rail}, 8'h00);
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_sel();
    t_mask();
    t_delay();
    t_codes();
    t_otp();
    tally_and_finish();
  end
endmodule // rail_enable_sequencer_tb
`default_nettype wire
